// ---- hw/ucil_top.sv ----
// module: interrupt enable, prioritising and status logic of one uart channel
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module ucil_top
#(
	parameter int FIFO_DEPTH = 64,
	parameter int CW = 7
)
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// configuration bits held by neighbouring registers
	input wire logic i_fifo_en,
	input wire logic i_ext_enable,
	input wire logic i_auto_cts_en,
	input wire logic i_auto_rts_en,
	input wire logic i_flow_sel_dtr,
	input wire logic i_auto_rs485,
	// receiver status
	input wire logic i_rx_char_in,
	input wire logic i_rx_err_new,
	input wire logic i_rx_err_at_head,
	input wire logic [3:0] i_head_err,
	input wire logic i_fifo_err_any,
	input wire logic i_rx_holding_full,
	input wire logic [CW-1:0] i_rx_count,
	input wire logic [CW-1:0] i_rx_trigger,
	input wire logic i_bit_tick,
	input wire logic [3:0] i_char_bits,
	// transmitter status
	input wire logic [CW-1:0] i_tx_count,
	input wire logic [CW-1:0] i_tx_trigger,
	input wire logic i_tx_holding_empty,
	input wire logic i_tx_shift_empty,
	// modem and flow pins
	input wire logic [3:0] i_msr_delta,
	input wire logic i_cts_pin,
	input wire logic i_dsr_pin,
	input wire logic i_rts_out,
	input wire logic i_dtr_out,
	// software flow character detection
	input wire logic i_xon_rx,
	input wire logic i_xoff_rx,
	input wire logic i_special_rx,
	// sleep and global interrupt register
	input wire logic i_wake,
	input wire logic i_global_read,
	// interrupt outputs
	output logic o_irq,
	output logic o_wake_irq,
	output logic [4:0] o_line_err
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256)
	begin : g_depth_bad
		$error("fifo depth out of range");
	end
	if (CW < $clog2(FIFO_DEPTH + 1))
	begin : g_cw_bad
		$error("count width too small for the fifo depth");
	end

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// status code of a source
	function automatic logic [5:0] ucil_code(input ucil_pkg::ucil_src_t src);
		logic [5:0] c;
		c = ucil_pkg::CODE_NONE;
		case (src)
			ucil_pkg::SRC_LINE: c = ucil_pkg::CODE_LINE;
			ucil_pkg::SRC_RX_DATA: c = ucil_pkg::CODE_RX_DATA;
			ucil_pkg::SRC_TIMEOUT: c = ucil_pkg::CODE_TIMEOUT;
			ucil_pkg::SRC_TX_READY: c = ucil_pkg::CODE_TX_READY;
			ucil_pkg::SRC_MODEM: c = ucil_pkg::CODE_MODEM;
			ucil_pkg::SRC_FLOW_CHAR: c = ucil_pkg::CODE_FLOW_CHAR;
			ucil_pkg::SRC_FLOW_PIN: c = ucil_pkg::CODE_FLOW_PIN;
			default: c = ucil_pkg::CODE_NONE;
		endcase
		return c;
	endfunction

	// highest priority set bit; index one is the highest level
	function automatic ucil_pkg::ucil_src_t ucil_pick(input logic [7:1] eff);
		ucil_pkg::ucil_src_t s;
		s = ucil_pkg::SRC_NONE;
		for (int i = 7; i >= 1; i--)
		begin
			if (eff[i])
			begin
				s = ucil_pkg::ucil_src_t'(i[2:0]);
			end
		end
		return s;
	endfunction

	// time-out length in bit times: four characters plus twelve bits
	function automatic logic [6:0] ucil_to_limit(input logic [3:0] bits);
		logic [6:0] lim;
		lim = 7'(ucil_pkg::TIMEOUT_CHARS * {3'h0, bits}) + ucil_pkg::TIMEOUT_BITS;
		return lim;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] interrupt_enable;
		logic [7:0] rdata;
		logic cts_s1;
		logic cts_s2;
		logic dsr_s1;
		logic dsr_s2;
		logic cts_prev;
		logic dsr_prev;
		logic rts_prev;
		logic dtr_prev;
		logic tx_above;
		logic tx_done_prev;
		logic line_p;
		logic timeout_p;
		logic tx_p;
		logic flow_char_p;
		logic flow_pin_p;
		logic wake_p;
		logic [6:0] to_cnt;
		ucil_pkg::ucil_src_t cur;
		logic irq;
		logic [4:0] line_err;
	} ucil_state_t;

	ucil_state_t s;
	ucil_state_t next_s;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic rd_ier;
	logic rd_isr;
	logic rd_line;
	logic rd_modem;
	logic rd_rhr;
	logic wr_ier;
	logic wr_thr;

	// strobes qualified by address; other addresses belong to neighbours
	assign rd_ier = i_rd && (i_addr == ucil_pkg::ADDR_INT_ENABLE);
	assign rd_isr = i_rd && (i_addr == ucil_pkg::ADDR_INT_STATUS);
	assign rd_line = i_rd && (i_addr == ucil_pkg::ADDR_LINE_STATUS);
	assign rd_modem = i_rd && (i_addr == ucil_pkg::ADDR_MODEM_STATUS);
	assign rd_rhr = i_rd && (i_addr == ucil_pkg::ADDR_RX_HOLDING);
	assign wr_ier = i_wr && (i_addr == ucil_pkg::ADDR_INT_ENABLE);
	assign wr_thr = i_wr && (i_addr == ucil_pkg::ADDR_RX_HOLDING);

	// ------------------------------------------------------------
	// event detection
	// ------------------------------------------------------------
	logic cts_rise;
	logic dsr_rise;
	logic rts_rise;
	logic dtr_rise;
	logic flow_in_rise;
	logic flow_out_rise;
	logic tx_below;
	logic tx_done;
	logic tx_evt;
	logic rx_data_lvl;
	logic rx_waiting;
	logic modem_lvl;

	// cts and dsr edges are taken from the second synchroniser stage; rts and dtr edges straight from the outputs
	assign cts_rise = s.cts_s2 && !s.cts_prev;
	assign dsr_rise = s.dsr_s2 && !s.dsr_prev;
	assign rts_rise = i_rts_out && !s.rts_prev;
	assign dtr_rise = i_dtr_out && !s.dtr_prev;
	assign flow_in_rise = i_flow_sel_dtr ? dsr_rise : cts_rise;
	assign flow_out_rise = i_flow_sel_dtr ? dtr_rise : rts_rise;

	// tx: first event on falling below trigger, second on empty
	assign tx_below = i_tx_count < i_tx_trigger;
	// with fifos on, half-duplex waits for the shift register as well
	assign tx_done = i_fifo_en
		? ((i_tx_count == '0) && (!i_auto_rs485 || i_tx_shift_empty))
		: i_tx_holding_empty;
	assign tx_evt = (tx_done && !s.tx_done_prev) || (i_fifo_en && tx_below && s.tx_above);

	// rx data is a level, so it clears by itself below trigger
	assign rx_data_lvl = i_fifo_en ? (i_rx_count >= i_rx_trigger) : i_rx_holding_full;
	assign rx_waiting = i_fifo_en && (i_rx_count != '0);
	assign modem_lvl = |i_msr_delta;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic [7:1] eff;
	logic [6:0] to_limit;
	logic cur_done;

	assign to_limit = ucil_to_limit(i_char_bits);

	// effective pending sources, gated by their enables
	always_comb
	begin
		eff = '0;
		eff[1] = s.line_p && s.interrupt_enable[ucil_pkg::IE_LINE];
		eff[2] = rx_data_lvl && s.interrupt_enable[ucil_pkg::IE_RX_DATA];
		eff[3] = s.timeout_p && s.interrupt_enable[ucil_pkg::IE_RX_DATA];
		eff[4] = s.tx_p && s.interrupt_enable[ucil_pkg::IE_TX_READY];
		eff[5] = modem_lvl && s.interrupt_enable[ucil_pkg::IE_MODEM];
		eff[6] = s.flow_char_p && s.interrupt_enable[ucil_pkg::IE_XOFF];
		// the flow-pin group is gated where its edges are latched, not here
		eff[7] = s.flow_pin_p;
	end

	// all state moves here; sets are applied after clears so they win
	always_comb
	begin
		next_s = s;

		// pin synchronisers and edge history
		next_s.cts_s1 = i_cts_pin;
		next_s.cts_s2 = s.cts_s1;
		next_s.dsr_s1 = i_dsr_pin;
		next_s.dsr_s2 = s.dsr_s1;
		next_s.cts_prev = s.cts_s2;
		next_s.dsr_prev = s.dsr_s2;
		next_s.rts_prev = i_rts_out;
		next_s.dtr_prev = i_dtr_out;
		next_s.tx_above = !tx_below;
		next_s.tx_done_prev = tx_done;

		// enable register; upper bits only with extended features on
		if (wr_ier)
		begin
			next_s.interrupt_enable = (i_wdata & ucil_pkg::IE_MASK_BASE)
				| (i_ext_enable ? (i_wdata & ucil_pkg::IE_MASK_EXT) : (s.interrupt_enable & ucil_pkg::IE_MASK_EXT));
		end

		// read data stands only in the cycle after the read strobe
		next_s.rdata = 8'h00;
		if (rd_ier)
		begin
			next_s.rdata = s.interrupt_enable & (ucil_pkg::IE_MASK_BASE | ucil_pkg::IE_MASK_EXT);
		end
		else if (rd_isr)
		begin
			next_s.rdata = {i_fifo_en, i_fifo_en, ucil_code(s.cur)};
		end

		// line status: cleared by reading the line status register
		if (rd_line)
		begin
			next_s.line_p = 1'b0;
		end
		if (i_rx_err_new || i_rx_err_at_head)
		begin
			next_s.line_p = 1'b1;
		end
		next_s.line_err = {i_fifo_err_any, i_head_err};

		// receive time-out counter runs in bit times while data waits
		if (rd_rhr || i_rx_char_in || !rx_waiting)
		begin
			next_s.to_cnt = 7'h00;
		end
		else if (i_bit_tick && (s.to_cnt < to_limit))
		begin
			next_s.to_cnt = s.to_cnt + 7'h01;
		end
		if (rd_rhr)
		begin
			next_s.timeout_p = 1'b0;
		end
		if (rx_waiting && !rd_rhr && !i_rx_char_in && i_bit_tick
			&& (s.to_cnt + 7'h01 == to_limit))
		begin
			next_s.timeout_p = 1'b1;
		end

		// transmit ready: status read while reported, or holding write
		if (wr_thr || (rd_isr && s.cur == ucil_pkg::SRC_TX_READY))
		begin
			next_s.tx_p = 1'b0;
		end
		if (tx_evt)
		begin
			next_s.tx_p = 1'b1;
		end

		// flow characters: status read while reported; special on next char
		if (rd_isr && s.cur == ucil_pkg::SRC_FLOW_CHAR)
		begin
			next_s.flow_char_p = 1'b0;
		end
		if (i_rx_char_in && !i_xon_rx && !i_xoff_rx)
		begin
			next_s.flow_char_p = 1'b0;
		end
		if (s.interrupt_enable[ucil_pkg::IE_XOFF] && (i_xoff_rx || i_xon_rx || i_special_rx))
		begin
			next_s.flow_char_p = 1'b1;
		end

		// flow pin changes: cleared by a modem status read
		if (rd_modem)
		begin
			next_s.flow_pin_p = 1'b0;
		end
		if ((s.interrupt_enable[ucil_pkg::IE_CTS] && cts_rise)
			|| (s.interrupt_enable[ucil_pkg::IE_RTS] && rts_rise)
			|| (i_auto_cts_en && flow_in_rise)
			|| (i_auto_rts_en && flow_out_rise))
		begin
			next_s.flow_pin_p = 1'b1;
		end

		// wake-up goes to the global register, not to the status code
		if (i_global_read)
		begin
			next_s.wake_p = 1'b0;
		end
		if (i_wake)
		begin
			next_s.wake_p = 1'b1;
		end

		// hold the reported source until its own clear, then re-pick
		if (cur_done)
		begin
			next_s.cur = ucil_pick(eff);
		end
		next_s.irq = (cur_done ? ucil_pick(eff) : s.cur) != ucil_pkg::SRC_NONE;
	end

	// the current source is finished once it no longer pends
	always_comb
	begin
		cur_done = 1'b1;
		if (s.cur != ucil_pkg::SRC_NONE)
		begin
			cur_done = !eff[s.cur];
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s <= '0;
			s.interrupt_enable <= ucil_pkg::INT_ENABLE_RESET;
			s.cur <= ucil_pkg::SRC_NONE;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_rdata = s.rdata;
	assign o_irq = s.irq;
	assign o_wake_irq = s.wake_p;
	assign o_line_err = s.line_err;

endmodule

`default_nettype wire

// ---- hw/ucil_pkg.sv ----
// package: shared constants and types of the uart channel interrupt logic
//
// Summary of operation
// - enabled cts rising edge raises interrupt
// - enabled rts output rising edge raises interrupt
// - xoff interrupt needs enable; upper enables need extension
// - any modem delta flag raises modem interrupt
// - overrun, framing, parity, break give line interrupt
// - line interrupt on arrival, again at head
// - queued error shows fifo flag; head flags only
// - tx interrupt: holding empty, or trigger then empty
// - half-duplex mode delays second tx interrupt
// - rx data interrupt: holding full or trigger reached
// - status read gives highest pending; others wait
// - reported source held until its own clear
// - time-out after four chars plus twelve bits
// - auto cts/dsr flow interrupts on selected rise
// - auto rts/dtr flow interrupts on selected rise
// - wake-up interrupt, cleared by global register read
// - line read clears line; modem read clears modem, flow
// - rx data clears below trigger; time-out on read
// - tx ready clears on status read or write
// - xon/xoff clear on status read; special also next char
// - six-bit source codes by priority one to seven
// - status bit zero low while anything pending
// - status bits seven, six follow fifo enable
package ucil_pkg;

	// register addresses on the plain register port
	localparam logic [3:0] ADDR_RX_HOLDING = 4'h0;
	localparam logic [3:0] ADDR_INT_ENABLE = 4'h1;
	localparam logic [3:0] ADDR_INT_STATUS = 4'h2;
	localparam logic [3:0] ADDR_LINE_STATUS = 4'h5;
	localparam logic [3:0] ADDR_MODEM_STATUS = 4'h6;

	// interrupt_enable fields and reset value
	localparam int IE_RX_DATA = 0;
	localparam int IE_TX_READY = 1;
	localparam int IE_LINE = 2;
	localparam int IE_MODEM = 3;
	localparam int IE_XOFF = 5;
	localparam int IE_RTS = 6;
	localparam int IE_CTS = 7;
	localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
	localparam logic [7:0] IE_MASK_BASE = 8'h0F;
	localparam logic [7:0] IE_MASK_EXT = 8'hE0;

	// interrupt_status source codes, bits five to zero
	localparam logic [5:0] CODE_LINE = 6'h06;
	localparam logic [5:0] CODE_RX_DATA = 6'h04;
	localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
	localparam logic [5:0] CODE_TX_READY = 6'h02;
	localparam logic [5:0] CODE_MODEM = 6'h00;
	localparam logic [5:0] CODE_FLOW_CHAR = 6'h10;
	localparam logic [5:0] CODE_FLOW_PIN = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [7:0] INT_STATUS_RESET = 8'h01;

	// receive time-out length in character times and bit times
	localparam logic [6:0] TIMEOUT_CHARS = 7'h04;
	localparam logic [6:0] TIMEOUT_BITS = 7'h0C;

	// interrupt sources in priority order, one highest
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_LINE = 3'b001,
		SRC_RX_DATA = 3'b010,
		SRC_TIMEOUT = 3'b011,
		SRC_TX_READY = 3'b100,
		SRC_MODEM = 3'b101,
		SRC_FLOW_CHAR = 3'b110,
		SRC_FLOW_PIN = 3'b111
	} ucil_src_t;

endpackage

// ---- test/ucil_host.sv ----
// host model: processor side of the channel register port
`timescale 1ns/10ps
`default_nettype none

module ucil_host
(
	// clock
	input wire logic i_clk,
	// register port toward the channel
	output logic [3:0] o_addr = 4'h0,
	output logic [7:0] o_wdata = 8'h00,
	output logic o_wr = 1'b0,
	output logic o_rd = 1'b0
);
	// ----------------------------------------
	// one bus cycle, called right after an edge
	// ----------------------------------------
	// strobes stand one cycle; an idle cycle follows so no strobe is driven twice in a step
	task automatic cyc(input logic w, input logic [3:0] a, input logic [7:0] d);
	begin
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_wdata <= ~d; // released data toggles so no stale value can pass
		@(posedge i_clk);
	end
	endtask
endmodule
`default_nettype wire

// ---- test/ucil_chk.sv ----
// checker: port-level properties of the channel interrupt logic
`timescale 1ns/10ps
`default_nettype none

module ucil_chk
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// watched inputs
	input wire logic [3:0] i_addr,
	input wire logic i_rd,
	input wire logic i_fifo_en,
	input wire logic i_fifo_err_any,
	input wire logic [3:0] i_head_err,
	input wire logic i_wake,
	input wire logic i_global_read,
	// watched outputs
	input wire logic [7:0] o_rdata,
	input wire logic o_irq,
	input wire logic o_wake_irq,
	input wire logic [4:0] o_line_err
);
	// ----------------------------------------
	// properties, one clock domain
	// ----------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside read answer");
	chk_fifo_bits: assert property ($past(i_rd && i_addr == 4'h2)
		|-> o_rdata[7:6] == {2{$past(i_fifo_en)}})
		else $error("status bits seven and six do not follow fifo enable");
	chk_pending_bit: assert property ($past(i_rd && i_addr == 4'h2)
		|-> o_rdata[0] == !$past(o_irq))
		else $error("status bit zero disagrees with request output");
	chk_code_legal: assert property ($past(i_rd && i_addr == 4'h2) |-> o_rdata[5:0]
		inside {6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
		else $error("status code is not a legal source code");
	chk_unmapped_zero: assert property ($past(i_rd && i_addr != 4'h1 && i_addr != 4'h2)
		|-> o_rdata == 8'h00)
		else $error("unmapped read returned data");
	chk_enable_rsvd: assert property ($past(i_rd && i_addr == 4'h1) |-> !o_rdata[4])
		else $error("reserved enable bit reads one");
	chk_line_flags: assert property (!$past(i_rst)
		|-> o_line_err == $past({i_fifo_err_any, i_head_err}))
		else $error("line error flags do not follow head and fifo flags");
	chk_wake_set: assert property (i_wake |-> ##[1:2] o_wake_irq)
		else $error("wake interrupt not raised");
	chk_wake_clear: assert property (i_global_read && !i_wake |-> ##[1:2] !o_wake_irq)
		else $error("wake interrupt not cleared by global read");
endmodule
`default_nettype wire

// ---- test/test_uart_channel_interrupt_logic.sv ----
// testbench: register-level tests of the channel interrupt logic
`timescale 1ns/10ps
`default_nettype none

module test_uart_channel_interrupt_logic;
	logic i_clk, i_rst, i_wr, i_rd, i_fifo_en, i_ext_enable, i_auto_cts_en, i_auto_rts_en;
	logic i_flow_sel_dtr, i_auto_rs485, i_rx_char_in, i_rx_err_new, i_rx_err_at_head;
	logic i_fifo_err_any, i_rx_holding_full, i_bit_tick, i_tx_holding_empty, i_tx_shift_empty;
	logic i_cts_pin, i_dsr_pin, i_rts_out, i_dtr_out, i_xon_rx, i_xoff_rx, i_special_rx;
	logic i_wake, i_global_read, o_irq, o_wake_irq;
	logic rd_seen = 1'b0;
	logic [3:0] i_addr, i_head_err, i_char_bits, i_msr_delta;
	logic [6:0] i_rx_count, i_rx_trigger, i_tx_count, i_tx_trigger;
	logic [7:0] i_wdata, o_rdata, exp;
	logic [4:0] o_line_err;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int checks_done = 0;

	ucil_top dut (.*);
	ucil_host h (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

	// ----------------------------------------
	// clock, bus tasks and read-answer monitor
	// ----------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
	begin
		exp_q.push_back(e);
		h.cyc(1'b0, a, 8'h00);
	end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic finish_test();
	begin
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	// answer stands only in the cycle after the read strobe, so look exactly there
	always @(posedge i_clk)
	begin
		if (rd_seen === 1'b1)
		begin
			exp = exp_q.pop_front();
			checks_done++;
			if (o_rdata !== exp)
			begin
				n_errors++;
				$display("MISMATCH o_rdata expected %h seen %h", exp, o_rdata);
			end
		end
		rd_seen <= i_rd;
	end
	// watchdog well beyond the few hundred cycles of the tests
	initial
	begin
		tk(5000);
		n_errors++;
		finish_test();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		{i_fifo_en, i_ext_enable, i_auto_cts_en, i_auto_rts_en, i_flow_sel_dtr, i_auto_rs485,
			i_rx_char_in, i_rx_err_new, i_rx_err_at_head, i_fifo_err_any, i_rx_holding_full,
			i_bit_tick, i_tx_holding_empty, i_tx_shift_empty, i_cts_pin, i_dsr_pin, i_rts_out,
			i_dtr_out, i_xon_rx, i_xoff_rx, i_special_rx, i_wake, i_global_read, i_head_err,
			i_char_bits, i_msr_delta, i_rx_count, i_rx_trigger, i_tx_count, i_tx_trigger} = '0;
		i_rst = 1'b1;
		void'($urandom(49104));
		tk(5);
		i_rst <= 1'b0;
		tk(1);
		// reset values, unmapped place, guarded upper enables
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h01);
		rd(4'h3, 8'h00);
		h.cyc(1'b1, 4'h1, 8'hFF);
		rd(4'h1, 8'h0F);
		i_ext_enable <= 1'b1;
		h.cyc(1'b1, 4'h1, 8'hFF);
		rd(4'h1, 8'hEF);
		done("enable");
		// line, rx data and modem pending together: served in priority order
		h.cyc(1'b1, 4'h1, 8'h0D);
		i_fifo_en <= 1'b1;
		i_rx_trigger <= 7'h04;
		i_head_err <= 4'h2;
		i_fifo_err_any <= 1'b1;
		i_rx_err_new <= 1'b1;
		tk(1);
		// level sources join once the line source is latched, so line is picked first
		i_rx_err_new <= 1'b0;
		i_rx_count <= 7'h04 + 7'($urandom % 4);
		i_msr_delta <= 4'h1 << ($urandom % 4);
		tk(3);
		rd(4'h2, 8'hC6);
		rd(4'h2, 8'hC6);
		rd(4'h5, 8'h00);
		tk(2);
		rd(4'h2, 8'hC4);
		i_rx_count <= 7'h03;
		tk(2);
		rd(4'h2, 8'hC0);
		i_msr_delta <= 4'h0;
		rd(4'h6, 8'h00);
		tk(2);
		rd(4'h2, 8'hC1);
		// errored character reaching the head raises the line source again
		i_rx_err_at_head <= 1'b1;
		tk(1);
		i_rx_err_at_head <= 1'b0;
		tk(3);
		rd(4'h2, 8'hC6);
		rd(4'h5, 8'h00);
		i_head_err <= 4'h0;
		i_fifo_err_any <= 1'b0;
		tk(2);
		rd(4'h2, 8'hC1);
		done("priority");
		// software flow character, cleared by the status read that reports it
		h.cyc(1'b1, 4'h1, 8'h20);
		i_xoff_rx <= 1'b1;
		tk(1);
		i_xoff_rx <= 1'b0;
		tk(3);
		rd(4'h2, 8'hD0);
		tk(2);
		rd(4'h2, 8'hC1);
		done("flow character");
		// rising pin edges of the input and of the own output
		for (int i = 0; i < 2; i++)
		begin
			h.cyc(1'b1, 4'h1, i ? 8'h40 : 8'h80);
			if (i)
				i_rts_out <= 1'b1;
			else
				i_cts_pin <= 1'b1;
			tk(6);
			rd(4'h2, 8'hE0);
			rd(4'h6, 8'h00);
			tk(2);
			rd(4'h2, 8'hC1);
		end
		done("flow pins");
		// time-out after four chars of eight bits plus twelve bits: 44 ticks
		h.cyc(1'b1, 4'h1, 8'h01);
		i_rx_trigger <= 7'h0A;
		i_rx_count <= 7'h01;
		i_char_bits <= 4'h8;
		i_rx_char_in <= 1'b1;
		tk(1);
		i_rx_char_in <= 1'b0;
		for (int k = 0; k < 44; k++)
		begin
			if (k == 43)
				rd(4'h2, 8'hC1);
			i_bit_tick <= 1'b1;
			tk(1);
			i_bit_tick <= 1'b0;
			tk(1);
		end
		tk(2);
		rd(4'h2, 8'hCC);
		rd(4'h0, 8'h00);
		tk(2);
		rd(4'h2, 8'hC1);
		done("time-out");
		// wake-up raised and cleared by the global register read
		i_wake <= 1'b1;
		tk(1);
		i_wake <= 1'b0;
		tk(3);
		i_global_read <= 1'b1;
		tk(1);
		i_global_read <= 1'b0;
		tk(3);
		done("wake-up");
		// transmit ready: empty and below-trigger events, both clears, half-duplex hold
		h.cyc(1'b1, 4'h1, 8'h02);
		rd(4'h2, 8'hC2);
		rd(4'h2, 8'hC1);
		i_tx_trigger <= 7'h08;
		i_tx_count <= 7'h10;
		tk(1);
		i_tx_count <= 7'h01 + 7'($urandom % 7);
		tk(3);
		rd(4'h2, 8'hC2);
		// masked event latches; a holding write must clear it before unmasking
		h.cyc(1'b1, 4'h1, 8'h00);
		i_tx_count <= 7'h00;
		tk(2);
		h.cyc(1'b1, 4'h0, 8'($urandom));
		h.cyc(1'b1, 4'h1, 8'h02);
		rd(4'h2, 8'hC1);
		i_auto_rs485 <= 1'b1;
		i_tx_count <= 7'h01;
		tk(2);
		i_tx_count <= 7'h00;
		tk(3);
		rd(4'h2, 8'hC1);
		i_tx_shift_empty <= 1'b1;
		tk(3);
		rd(4'h2, 8'hC2);
		done("transmit ready");
		// automatic flow control with the dsr and dtr pins selected
		h.cyc(1'b1, 4'h1, 8'h00);
		i_flow_sel_dtr <= 1'b1;
		i_auto_cts_en <= 1'b1;
		i_dsr_pin <= 1'b1;
		tk(6);
		rd(4'h2, 8'hE0);
		rd(4'h6, 8'h00);
		i_auto_rts_en <= 1'b1;
		i_dtr_out <= 1'b1;
		tk(3);
		rd(4'h2, 8'hE0);
		rd(4'h6, 8'h00);
		tk(2);
		rd(4'h2, 8'hC1);
		done("auto flow");
		// without fifos the holding register alone raises rx data
		i_fifo_en <= 1'b0;
		i_rx_holding_full <= 1'b1;
		h.cyc(1'b1, 4'h1, 8'h01);
		rd(4'h2, 8'h04);
		done("no fifo");
		finish_test();
	end
endmodule

bind ucil_top ucil_chk chk (.*);
`default_nettype wire
